/* File: verilog/adc_control.v */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "adc_control_regs.vh"

// Contract
// - Reference field bits 7:5 selects conversion reference
// - Reference change applies after conversion completes
// - Reference register bit 2 reads zero
// - Gain field bits 1:0 sets amplification
// - Low byte read locks result until high
// - Left adjust places result high; else low
// - Left adjust change rearranges result immediately
// - Enable clear powers off, aborts conversion
// - Start begins one, or first free-running
// - First conversion 26 clocks, later 15
// - Start reads one while running; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag sets on finish; clears
// - Interrupt when flag, enable, global enable
// - Prescaler divides system clock 2..128
// - Trigger source ignored without auto trigger
// - Switching to set source counts as edge
// - Selecting free running makes no trigger
// - Disable bit forces pin input zero
// - Second disable register bits 7:4 read zero
// - Channel change applies after conversion completes
module adc_control (
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Analog core
    output reg         converter_power,
    output reg         sample_start,
    output reg  [2:0]  reference_select,
    output wire        external_reference_pin,
    output reg  [1:0]  gain_select,
    output reg  [5:0]  channel_select,
    input  wire [9:0]  core_result,
    // Trigger flags, index 1..7 used
    input  wire [7:1]  trigger_flags,
    // Interrupt
    input  wire        global_irq_enable,
    input  wire        irq_ack,
    output wire        conversion_irq,
    // Pins
    input  wire [11:0] pin_raw,
    output wire [11:0] port_input_bit,
    output wire [11:0] pin_input_disable
);

    // Software-facing registers
    reg  [5:0]  chan_sw_q;        // Channel requested by software
    reg  [7:0]  ref_gain_q;       // Requested reference and gain
    reg         enable_q;
    reg         auto_q;
    reg         done_q;
    reg         irq_en_q;
    reg  [2:0]  prescale_q;
    reg         left_adjust_q;
    reg  [2:0]  trig_src_q;
    reg  [7:0]  dis_low_q;
    reg  [3:0]  dis_high_q;
    // Conversion engine
    reg         busy_q;
    reg         first_q;          // Next conversion initialises
    reg  [7:0]  conv_cnt_q;       // Converter clocks left
    reg  [6:0]  pre_cnt_q;        // Prescaler counter
    reg  [9:0]  result_q;
    reg         lock_q;           // Low read, high pending
    reg         trig_prev_q;
    reg  [2:0]  src_prev_q;       // Trigger source seen last cycle
    reg         ack_q;            // One-cycle answer phase

    // Selected trigger signal; free running uses the done flag
    wire        trig_sel = (trig_src_q == 3'h0) ? done_q : trigger_flags[trig_src_q];
    wire        free_run  = (trig_src_q == 3'h0);
    // Entering free running with the flag already set must not look like an edge
    wire        into_free = free_run & (trig_src_q != src_prev_q);
    // Switching source to a set flag looks like an edge here, except free running
    wire        trig_edge = trig_sel & ~trig_prev_q & ~into_free;
    // Writes and read side effects happen only at the edge that ends the wait
    wire        bus_wr    = write & ack_q;
    wire        bus_rd    = read & ack_q;
    // Read data is fetched during the wait cycle so it stands at the taking edge
    wire        rd_load   = read & ~ack_q;
    wire        wr_csra   = bus_wr & (address == `OFF_CSR_A);
    wire        sw_start  = wr_csra & writedata[`CSRA_START]
                            & writedata[`CSRA_ENABLE];
    wire        auto_go   = enable_q & auto_q & trig_edge;
    wire        start_go  = ~busy_q & (sw_start | auto_go);
    wire        abort     = wr_csra & ~writedata[`CSRA_ENABLE];

    // Prescaler division terminal count
    reg  [6:0]  pre_max;
    always @* begin
        case (prescale_q)
            3'h0, 3'h1: pre_max = 7'h01;
            3'h2:       pre_max = 7'h03;
            3'h3:       pre_max = 7'h07;
            3'h4:       pre_max = 7'h0F;
            3'h5:       pre_max = 7'h1F;
            3'h6:       pre_max = 7'h3F;
            default:    pre_max = 7'h7F;
        endcase
    end
    wire        adc_tick  = (pre_cnt_q >= pre_max);
    wire        conv_end  = busy_q & adc_tick & (conv_cnt_q == 8'h01);

    // Every access answered after one wait cycle
    assign waitrequest = (read | write) & ~ack_q;

    // Answer phase toggles so back-to-back requests each wait once
    always @(posedge clock) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // Result view, live with left adjust
    wire [15:0] result_view = left_adjust_q ? {result_q, 6'h00}
                                            : {6'h00, result_q};

    // Read data register
    always @(posedge clock) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (rd_load) begin
            case (address)
                `OFF_CHANNEL_SEL: readdata <= {26'h0, chan_sw_q};
                `OFF_REF_GAIN:    readdata <= {24'h0, ref_gain_q & `REF_GAIN_MASK};
                `OFF_CSR_A:       readdata <= {24'h0, enable_q, busy_q, auto_q,
                                               done_q, irq_en_q, prescale_q};
                `OFF_CSR_B:       readdata <= {28'h0, left_adjust_q, trig_src_q};
                `OFF_DIS_LOW:     readdata <= {24'h0, dis_low_q};
                `OFF_DIS_HIGH:    readdata <= {28'h0, dis_high_q};
                `OFF_RESULT_LOW:  readdata <= {24'h0, result_view[7:0]};
                `OFF_RESULT_HIGH: readdata <= {24'h0, result_view[15:8]};
                default:          readdata <= 32'h0000_0000;  // Unmapped reads zero
            endcase
        end
    end

    // Software register writes and done flag
    always @(posedge clock) begin
        if (!nrst) begin
            chan_sw_q     <= 6'h00;
            ref_gain_q    <= 8'h00;
            enable_q      <= 1'b0;
            auto_q        <= 1'b0;
            done_q        <= 1'b0;
            irq_en_q      <= 1'b0;
            prescale_q    <= 3'h0;
            left_adjust_q <= 1'b0;
            trig_src_q    <= 3'h0;
            dis_low_q     <= 8'h00;
            dis_high_q    <= 4'h0;
        end else begin
            if (bus_wr) begin
                case (address)
                    `OFF_CHANNEL_SEL: chan_sw_q <= writedata[5:0];
                    `OFF_REF_GAIN:    ref_gain_q <= writedata[7:0] & `REF_GAIN_MASK;
                    `OFF_CSR_A: begin
                        enable_q   <= writedata[`CSRA_ENABLE];
                        auto_q     <= writedata[`CSRA_AUTO];
                        irq_en_q   <= writedata[`CSRA_IRQ_EN];
                        prescale_q <= writedata[2:0];
                    end
                    `OFF_CSR_B: begin
                        left_adjust_q <= writedata[`CSRB_LEFT_ADJUST];
                        trig_src_q    <= writedata[2:0];
                    end
                    `OFF_DIS_LOW:  dis_low_q  <= writedata[7:0];
                    `OFF_DIS_HIGH: dis_high_q <= writedata[3:0];
                    default: begin
                        // Unmapped writes dropped
                    end
                endcase
            end
            // Completion sets, winning over clears in the same cycle
            if (conv_end) begin
                done_q <= 1'b1;
            end else if (irq_ack | (wr_csra & writedata[`CSRA_DONE])) begin
                done_q <= 1'b0;
            end
        end
    end

    // Conversion engine: prescaler, counter, result capture
    always @(posedge clock) begin
        if (!nrst) begin
            busy_q           <= 1'b0;
            first_q          <= 1'b1;
            conv_cnt_q       <= 8'h00;
            pre_cnt_q        <= 7'h00;
            result_q         <= 10'h000;
            lock_q           <= 1'b0;
            trig_prev_q      <= 1'b0;
            src_prev_q       <= 3'h0;
            sample_start     <= 1'b0;
            converter_power  <= 1'b0;
            reference_select <= 3'h0;
            gain_select      <= 2'h0;
            channel_select   <= 6'h00;
        end else begin
            trig_prev_q     <= trig_sel;
            src_prev_q      <= trig_src_q;
            sample_start    <= start_go & ~abort;
            converter_power <= enable_q;
            // Prescaler only runs while enabled, saves power otherwise
            // Restart at each start so a conversion lasts whole converter clocks
            pre_cnt_q <= (adc_tick | ~enable_q | start_go) ? 7'h00 : pre_cnt_q + 7'h01;
            // Byte lock: low read sets, high read clears
            if (bus_rd & (address == `OFF_RESULT_LOW)) begin
                lock_q <= 1'b1;
            end else if (bus_rd & (address == `OFF_RESULT_HIGH)) begin
                lock_q <= 1'b0;
            end
            if (abort) begin
                busy_q  <= 1'b0;
                first_q <= 1'b1;
            end else if (start_go) begin
                busy_q     <= 1'b1;
                conv_cnt_q <= first_q ? `FIRST_CONV_CYCLES
                                      : `NORMAL_CONV_CYCLES;
                first_q    <= 1'b0;
            end else if (conv_end) begin
                // Free running with auto trigger restarts via done flag edge
                busy_q <= 1'b0;
                if (!lock_q) begin
                    result_q <= core_result;
                end
            end else if (busy_q & adc_tick) begin
                conv_cnt_q <= conv_cnt_q - 8'h01;
            end
            // Selections follow software only while idle
            if (!busy_q) begin
                reference_select <= ref_gain_q[7:5];
                gain_select      <= ref_gain_q[1:0];
                channel_select   <= chan_sw_q;
            end
        end
    end

    // Codes 100 and above connect the reference pin
    assign external_reference_pin = reference_select[2];
    assign conversion_irq = done_q & irq_en_q & global_irq_enable;
    assign pin_input_disable = {dis_high_q, dis_low_q};

    // Per-pin input gating
    genvar i;
    generate
        for (i = 0; i < 12; i = i + 1) begin : pin_gate
            assign port_input_bit[i] = pin_raw[i] & ~pin_input_disable[i];
        end
    endgenerate

endmodule
`default_nettype wire

/* File: verilog/adc_control_regs.vh */
`ifndef ADC_CONTROL_REGS_VH
`define ADC_CONTROL_REGS_VH
// Register word offsets (one per word, data in low byte)
`define OFF_CHANNEL_SEL     4'h0
`define OFF_REF_GAIN        4'h1
`define OFF_CSR_A           4'h2
`define OFF_CSR_B           4'h3
`define OFF_DIS_LOW         4'h4
`define OFF_DIS_HIGH        4'h5
`define OFF_RESULT_LOW      4'h6
`define OFF_RESULT_HIGH     4'h7
// Control and status A fields
`define CSRA_ENABLE         7
`define CSRA_START          6
`define CSRA_AUTO           5
`define CSRA_DONE           4
`define CSRA_IRQ_EN         3
// Control and status B fields
`define CSRB_LEFT_ADJUST    3
// Reference and gain mask (bits 4:2 reserved)
`define REF_GAIN_MASK       8'hE3
`define CSRB_MASK           8'h0F
`define DIS_HIGH_MASK       8'h0F
// Conversion lengths in converter clocks
`define FIRST_CONV_CYCLES   8'h1A
`define NORMAL_CONV_CYCLES  8'h0F
`endif

/* File: bench/adc_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_control_props (
    // Clock and bus
    input wire        clock,
    input wire        nrst,
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    // Core, interrupt and pins
    input wire        converter_power,
    input wire        sample_start,
    input wire [2:0]  reference_select,
    input wire        external_reference_pin,
    input wire [5:0]  channel_select,
    input wire        global_irq_enable,
    input wire        conversion_irq,
    input wire [11:0] pin_raw,
    input wire [11:0] port_input_bit,
    input wire [11:0] pin_input_disable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Read answered in this cycle
    wire rd_done = read && !waitrequest;
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request waited more than one cycle");
    a_ext_ref: assert property (external_reference_pin == reference_select[2])
        else $error("reference pin connect wrong");
    a_ref_res_zero: assert property (rd_done && address == 4'h1 |-> !readdata[2])
        else $error("reserved reference bit read one");
    a_dis_res_zero: assert property (rd_done && address == 4'h5 |-> readdata[7:4] == 4'h0)
        else $error("reserved disable bits read nonzero");
    a_pin_gate: assert property (port_input_bit == (pin_raw & ~pin_input_disable))
        else $error("disabled pin input not forced low");
    a_irq_gate: assert property (conversion_irq |-> global_irq_enable)
        else $error("interrupt without global enable");
    a_start_pulse: assert property (sample_start |=> !sample_start)
        else $error("start pulse longer than one cycle");
    // Shortest conversion is 30 clocks, so selections hold well past 8
    a_sel_hold: assert property (sample_start |=> $stable({reference_select, channel_select})[*8])
        else $error("selection changed during conversion");
    a_power_off: assert property (write && !waitrequest && address == 4'h2 && !writedata[7]
        |-> ##[1:2] !converter_power)
        else $error("converter stayed powered after disable");
    c_start: cover property (sample_start);
    c_irq: cover property (conversion_irq);
    c_high_read: cover property (rd_done && address == 4'h7);
endmodule
bind adc_control adc_control_props adc_control_props_inst (.clock, .nrst, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .converter_power, .sample_start,
    .reference_select, .external_reference_pin, .channel_select, .global_irq_enable,
    .conversion_irq, .pin_raw, .port_input_bit, .pin_input_disable);
`default_nettype wire

/* File: bench/tb_adc_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control;
    // Driven inputs
    logic clock = 0, nrst = 0, read = 0, write = 0, global_irq_enable = 1, irq_ack = 0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [9:0] core_result = 10'h000;
    logic [7:1] trigger_flags = 7'h00;
    logic [11:0] pin_raw = 12'h000;
    // Observed outputs
    wire [31:0] readdata;
    wire waitrequest, converter_power, sample_start, ext_ref, conversion_irq;
    wire [2:0] reference_select;
    wire [1:0] gain_select;
    wire [5:0] channel_select;
    wire [11:0] port_input_bit, pin_input_disable;
    // Expected reads as {mask, value}, oldest first
    logic [15:0] q[$];
    logic [15:0] m;
    logic [7:0] r, v;
    int fail_count = 0, checked = 0, cyc = 0, cycles = 0;
    adc_control adc_control_inst (.clock, .nrst, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .converter_power, .sample_start, .reference_select,
        .external_reference_pin(ext_ref), .gain_select, .channel_select, .core_result,
        .trigger_flags, .global_irq_enable, .irq_ack, .conversion_irq, .pin_raw,
        .port_input_bit, .pin_input_disable);
    initial begin
        forever #2 clock = ~clock;
    end
    // Cycles since the last conversion start
    always @(posedge clock) cyc <= sample_start ? 1 : cyc + 1;
    // Hang guard, well above the longest run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            end_of_test;
        end
    end
    // Read answer checker, masked bits only
    always @(posedge clock) if (read && waitrequest === 1'b0 && q.size() > 0) begin
        m = q.pop_front();
        chk("readdata", {8'h00, m[7:0] & m[15:8]}, {8'h00, readdata[7:0] & m[15:8]});
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // One Avalon transfer; waitrequest sampled at rising edges, released after the taking edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [15:0] x);
        address <= a;
        writedata <= {24'h000000, d};
        write <= w;
        read <= !w;
        if (!w) q.push_back(x);
        do @(posedge clock); while (waitrequest !== 1'b0);
        read <= 0;
        write <= 0;
        @(posedge clock);
    endtask
    task automatic wirq(input int e);
        do @(negedge clock); while (conversion_irq !== 1'b1);
        chk("conv cycles", 16'(e), 16'((cyc >= e - 2 && cyc <= e + 6) ? e : cyc));
        @(posedge clock);
    endtask
    // Start, move reference mid-run, check results, gate and acknowledge
    task automatic conv(input logic [7:0] c, input int e);
        logic [2:0] o;
        o = reference_select;
        r = $urandom;
        core_result <= $urandom;
        bus(1, 4'h2, c, 16'h0000);
        bus(0, 4'h2, 8'h00, 16'h4040);
        bus(1, 4'h1, {r[2:0], 5'h00}, 16'h0000);
        chk("ref held", {13'h0000, o}, {13'h0000, reference_select});
        wirq(e);
        bus(0, 4'h2, 8'h00, 16'h5010);
        chk("ref applied", {13'h0000, r[2:0]}, {13'h0000, reference_select});
        bus(0, 4'h6, 8'h00, {8'hFF, core_result[7:0]});
        bus(0, 4'h7, 8'h00, {8'hFF, 6'h00, core_result[9:8]});
        global_irq_enable <= 0;
        @(negedge clock);
        chk("irq gated", 16'h0000, {15'h0000, conversion_irq});
        @(posedge clock);
        global_irq_enable <= 1;
        irq_ack <= 1;
        @(posedge clock);
        irq_ack <= 0;
        @(negedge clock);
        chk("irq ack", 16'h0000, {15'h0000, conversion_irq});
        @(posedge clock);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        v = 8'($urandom(32'hDD5256E4));
        repeat (20) @(posedge clock);
        nrst <= 1;
        @(posedge clock);
        for (int a = 1; a < 9; a++) bus(0, 4'(a), 8'h00, 16'hFF00);
        bus(1, 4'h1, 8'hFF, 16'h0000);
        bus(1, 4'h5, 8'hFF, 16'h0000);
        bus(0, 4'h1, 8'h00, 16'hFFE3);
        bus(0, 4'h5, 8'h00, 16'hFF0F);
        chk("ref gain", 16'h001F, {11'h000, reference_select, gain_select});
        pin_raw <= $urandom;
        bus(1, 4'h4, v, 16'h0000);
        bus(0, 4'h4, 8'h00, {8'hFF, v});
        chk("pin gate", {4'h0, pin_raw & ~{4'hF, v}}, {4'h0, port_input_bit});
        $display("test registers done");
        conv(8'hC8, 52);
        bus(1, 4'h3, 8'h08, 16'h0000);
        bus(0, 4'h6, 8'h00, {8'hFF, core_result[1:0], 6'h00});
        bus(0, 4'h7, 8'h00, {8'hFF, core_result[9:2]});
        bus(1, 4'h3, 8'h00, 16'h0000);
        for (int p = 0; p < 8; p++) conv(8'hC8 | 8'(p), 15 * (p < 2 ? 2 : 1 << p));
        $display("test conversions done");
        bus(1, 4'h2, 8'hC8, 16'h0000);
        bus(1, 4'h2, 8'h08, 16'h0000);
        bus(0, 4'h2, 8'h00, 16'hFF08);
        chk("power", 16'h0000, {15'h0000, converter_power});
        conv(8'hC8, 52);
        $display("test abort done");
        bus(1, 4'h3, 8'h01, 16'h0000);
        trigger_flags <= 7'h01;
        repeat (40) @(posedge clock);
        bus(0, 4'h2, 8'h00, 16'h5000);
        trigger_flags <= 7'h00;
        bus(1, 4'h2, 8'hA8, 16'h0000);
        trigger_flags <= 7'h01;
        wirq(30);
        bus(1, 4'h2, 8'hB8, 16'h0000);
        chk("flag clear", 16'h0000, {15'h0000, conversion_irq});
        trigger_flags <= 7'h03;
        bus(1, 4'h3, 8'h03, 16'h0000);
        bus(1, 4'h3, 8'h02, 16'h0000);
        wirq(30);
        $display("test auto trigger done");
        end_of_test;
    end
endmodule
`default_nettype wire
